// >>> hdl/ubf_core.v
`timescale 1ns/1ps
`default_nettype none
`include "ubf_regs.vh"
module ubf_core #(
    parameter DATA_W = `UBF_DATA_W,
    parameter DEPTH  = `UBF_FIFO_DEPTH
) (
    // clocking
    input  wire              clk,
    input  wire              resetn,
    input  wire              ce,
    // configuration
    input  wire [3:0]        operating_mode,
    input  wire              sync_mode,
    input  wire [15:0]       baud_div,
    input  wire              rx_enable,
    input  wire              tx_enable,
    input  wire              parity_en,
    input  wire              reset_status_bits,
    // dma receive buffer state
    input  wire              rx_dma_buffer_full,
    // transmit data, from dma or direct write
    input  wire              tx_valid,
    output wire              tx_ready,
    input  wire [DATA_W-1:0] tx_data,
    // receive data
    output reg               rx_valid,
    output reg  [DATA_W-1:0] rx_data,
    // status
    output reg               break_received_flag,
    output reg               frame_error_flag,
    output reg               tx_busy,
    // line
    input  wire              rxd,
    input  wire              cts,
    output reg               txd,
    output reg               rts
);
    // ****************************************
    // receiver
    // ****************************************
    localparam RX_IDLE = 4'b0001;
    localparam RX_BITS = 4'b0010;
    localparam RX_BRK  = 4'b0100;
    localparam RX_END  = 4'b1000;
    localparam NB      = DATA_W + 2;

    reg [3:0]  rx_st_r;
    reg [15:0] rx_div_r;
    reg [3:0]  rx_smp_r;
    reg [3:0]  rx_bit_r;
    reg [NB-1:0] rx_sh_r;
    reg        rx_all0_r;
    reg [3:0]  hi_cnt_r;
    wire       rx_tick = (rx_div_r == 16'h0000);
    wire       hs      = (operating_mode == `UBF_MODE_HANDSHAKE);
    wire [3:0] last_bit = parity_en ? DATA_W[3:0] + 4'h1 : DATA_W[3:0];
    // sync mode takes every tick as a bit sample; async takes the middle of sixteen
    wire       samp = sync_mode ? rx_tick
                                : (rx_tick & (rx_smp_r == 4'h7));

    function [15:0] div_reload;
        input [15:0] d;
        begin
            div_reload = (d == 16'h0000) ? 16'h0000 : d - 16'h0001;
        end
    endfunction

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_st_r   <= RX_IDLE;
            rx_div_r  <= 16'h0000;
            rx_smp_r  <= 4'h0;
            rx_bit_r  <= 4'h0;
            rx_sh_r   <= {NB{1'b0}};
            rx_all0_r <= 1'b0;
            hi_cnt_r  <= 4'h0;
            rx_valid  <= 1'b0;
            rx_data   <= {DATA_W{1'b0}};
            frame_error_flag    <= 1'b0;
            break_received_flag <= 1'b0;
        end
        else if (ce)
        begin
            rx_valid <= 1'b0;
            rx_div_r <= rx_tick ? div_reload(baud_div) : rx_div_r - 16'h0001;
            if (rx_tick)
                rx_smp_r <= rx_smp_r + 4'h1;
            // clear first so a same-cycle set below wins
            if (reset_status_bits)
            begin
                break_received_flag <= 1'b0;
                frame_error_flag    <= 1'b0;
            end
            case (rx_st_r)
                RX_IDLE:
                begin
                    if (rx_enable & ~rxd)
                    begin
                        rx_st_r   <= RX_BITS;
                        rx_smp_r  <= 4'h0;
                        rx_div_r  <= div_reload(baud_div);
                        // in sync mode the idle detect already was the start sample
                        rx_bit_r  <= sync_mode ? 4'h1 : 4'h0;
                        rx_all0_r <= 1'b1;
                    end
                end
                RX_BITS:
                begin
                    if (!rx_enable)
                        rx_st_r <= RX_IDLE;
                    else if (samp)
                    begin
                        rx_sh_r  <= {rxd, rx_sh_r[NB-1:1]};
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r != 4'h0)
                            rx_all0_r <= rx_all0_r & ~rxd;
                        if (rx_bit_r == last_bit + 4'h1)
                        begin
                            // stop bit sample
                            if (rx_all0_r & ~rxd)
                            begin
                                break_received_flag <= 1'b1;
                                rx_st_r  <= RX_BRK;
                                hi_cnt_r <= 4'h0;
                            end
                            else
                            begin
                                rx_valid <= 1'b1;
                                rx_data  <= parity_en ? rx_sh_r[NB-2:1] : rx_sh_r[NB-1:2];
                                if (~rxd)
                                    frame_error_flag <= 1'b1;
                                rx_st_r <= RX_IDLE;
                            end
                        end
                    end
                end
                RX_BRK:
                begin
                    // a break never reaches the framing-error flag
                    if (sync_mode & samp & rxd)
                        rx_st_r <= RX_END;
                    else if (~sync_mode & rx_tick)
                    begin
                        hi_cnt_r <= rxd ? hi_cnt_r + 4'h1 : 4'h0;
                        if (rxd & (hi_cnt_r == `UBF_END_ASYNC_SMP - 1))
                            rx_st_r <= RX_END;
                    end
                end
                RX_END:
                begin
                    break_received_flag <= 1'b1;
                    rx_st_r <= RX_IDLE;
                end
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // rts: high out of reset; in handshake mode high when receiver off or dma buffer full, else low; low in other modes
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rts <= 1'b1;
        else if (ce)
            rts <= hs ? (~rx_enable | rx_dma_buffer_full) : 1'b0;
    end

    // ****************************************
    // transmit path through the fifo
    // ****************************************
    wire              f_valid;
    reg               f_ready;
    wire [DATA_W-1:0] f_data;

    // dma and direct writes share this port, so flow control covers both
    ubf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(4)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    reg [15:0]   tx_div_r;
    reg [3:0]    tx_smp_r;
    reg [3:0]    tx_bit_r;
    reg [NB:0]   tx_sh_r;
    wire         tx_bit_end = (tx_div_r == 16'h0000) &
                              (sync_mode | (tx_smp_r == `UBF_OVERSAMPLE - 1));
    // cts is only sampled between characters; a started character runs out
    wire         go = tx_enable & f_valid & ~tx_busy & ~(hs & cts);

    always @*
    begin
        f_ready = go;
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_busy  <= 1'b0;
            txd      <= 1'b1;
            tx_div_r <= 16'h0000;
            tx_smp_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_sh_r  <= {(NB+1){1'b1}};
        end
        else if (ce)
        begin
            if (go)
            begin
                tx_busy  <= 1'b1;
                txd      <= 1'b0;
                tx_sh_r  <= parity_en ? {1'b1, ^f_data, f_data, 1'b0}
                                      : {1'b1, 1'b1, f_data, 1'b0};
                tx_bit_r <= 4'h0;
                tx_smp_r <= 4'h0;
                tx_div_r <= div_reload(baud_div);
            end
            else if (tx_busy)
            begin
                tx_div_r <= (tx_div_r == 16'h0000) ? div_reload(baud_div)
                                                   : tx_div_r - 16'h0001;
                if (tx_div_r == 16'h0000)
                    tx_smp_r <= tx_smp_r + 4'h1;
                if (tx_bit_end)
                begin
                    tx_sh_r  <= {1'b1, tx_sh_r[NB:1]};
                    txd      <= tx_sh_r[1];
                    tx_bit_r <= tx_bit_r + 4'h1;
                    if (tx_bit_r == last_bit + 4'h1)
                    begin
                        tx_busy <= 1'b0;
                        txd     <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ubf_fifo.v
`timescale 1ns/1ps
`default_nettype none
module ubf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clocking
    input  wire             clk,
    input  wire             resetn,
    input  wire             ce,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            push = ce & in_valid & in_ready;
    wire            pop  = ce & out_valid & out_ready;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rp_r];

    always @(posedge clk)
    begin
        if (push)
            mem[wp_r] <= in_data;
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> shared/ubf_regs.vh
`ifndef UBF_REGS_VH
`define UBF_REGS_VH
`define UBF_MODE_W          4
`define UBF_MODE_HANDSHAKE  4'h2
`define UBF_OVERSAMPLE      16
`define UBF_END_ASYNC_SMP   2
`define UBF_DATA_W          8
`define UBF_FIFO_DEPTH      16
`define UBF_DIV_W           16
`define UBF_DIV_RESET       16'h0000
`endif

// >>> tb/tb_usart_break_rx_and_rts_cts_flow.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubf_regs.vh"
module tb_usart_break_rx_and_rts_cts_flow;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, sync_mode = 1'b0, rx_en = 1'b0, tx_en = 1'b0;
    logic rst_sts = 1'b0, full = 1'b0, tx_valid = 1'b0, cts = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [7:0] tx_data = 8'h00, got, b;
    wire tx_ready, rx_valid, brk, fe, tx_busy, txd, rts, rxd;
    wire [7:0] rx_data;
    int n_errors = 0, n_checks = 0, cyc = 0, ngot = 0, n, i;
    // {mode, rx enable, buffer full, expected rts}
    logic [6:0] rows [0:7] = '{7'h11, 7'h14, 7'h17, 7'h13, 7'h14, 7'h02, 7'h18, 7'h0e};
    always #25 clk = ~clk;
    ubf_core uut (
        .clk(clk), .resetn(resetn), .ce(ce), .operating_mode(mode), .sync_mode(sync_mode),
        .baud_div(16'h0000), .rx_enable(rx_en), .tx_enable(tx_en), .parity_en(1'b0),
        .reset_status_bits(rst_sts), .rx_dma_buffer_full(full), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
        .break_received_flag(brk), .frame_error_flag(fe), .tx_busy(tx_busy),
        .rxd(rxd), .cts(cts), .txd(txd), .rts(rts)
    );
    ubf_remote rem (.clk(clk), .rts(rts), .txd(txd), .rxd(rxd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic clr;
        rst_sts <= 1'b1;
        @(posedge clk);
        rst_sts <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (rx_valid === 1'b1)
        begin
            got = rx_data;
            ngot++;
        end
        if (cyc == 20000)
        begin
            n_errors++;
            results;
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        tx_en <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            {mode, rx_en, full} <= rows[i][6:1];
            repeat (2) @(posedge clk);
            chk(8'(rts), 8'(rows[i][0]));
        end
        // frozen clock enable must hide the mode change from rts
        ce <= 1'b0;
        mode <= `UBF_MODE_HANDSHAKE;
        repeat (3) @(posedge clk);
        chk(8'(rts), 8'h00);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk(8'(rts), 8'h01);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk(8'({txd, rts, brk, fe, tx_busy}), 8'h18);
        resetn <= 1'b1;
        @(posedge clk);
        fork
            rem.send(8'ha5);
        join_none
        repeat (100) @(posedge clk);
        chk(ngot[7:0], 8'h00);
        // software hands the dma channel a fresh receive buffer
        full <= 1'b0;
        repeat (250) @(posedge clk);
        chk(got, 8'ha5);
        chk(ngot[7:0], 8'h01);
        rem.hold(1'b0, 12 * 16);
        chk(8'({brk, fe}), 8'h02);
        clr;
        chk(8'(brk), 8'h00);
        // one high tick is a glitch, not the end of the break
        rem.hold(1'b1, 1);
        rem.hold(1'b0, 40);
        chk(8'(brk), 8'h00);
        rem.hold(1'b1, 6);
        chk(8'(brk), 8'h01);
        rem.hold(1'b1, 40);
        // a low stop bit after non-zero data is a real framing error
        clr;
        rem.hold(1'b0, 16);
        rem.hold(1'b1, 8 * 16);
        rem.hold(1'b0, 16);
        chk(8'({brk, fe}), 8'h01);
        // the low tail starts one more character; let it run out
        rem.hold(1'b1, 200);
        sync_mode <= 1'b1;
        rem.bitc = 1;
        clr;
        chk(8'({brk, fe}), 8'h00);
        rem.hold(1'b0, 14);
        chk(8'(brk), 8'h01);
        clr;
        rem.hold(1'b1, 1);
        rem.hold(1'b0, 3);
        chk(8'(brk), 8'h01);
        rem.hold(1'b1, 30);
        sync_mode <= 1'b0;
        rem.bitc = 16;
        cts <= 1'b1;
        tx_valid <= 1'b1;
        n = 0;
        repeat (20)
        begin
            tx_data <= 8'h30 + n[7:0];
            @(posedge clk);
            if (tx_ready === 1'b1) n++;
        end
        tx_valid <= 1'b0;
        chk(n[7:0], 8'h10);
        chk(8'({tx_busy, txd}), 8'h01);
        cts <= 1'b0;
        // cts rises inside a character: it finishes, the next one waits
        for (i = 0; i < 16; i++)
        begin
            if (i == 1)
            begin
                while (txd !== 1'b0) @(posedge clk);
                cts <= 1'b1;
            end
            rem.get(b);
            chk(b, 8'h30 + i[7:0]);
            if (i == 1)
            begin
                repeat (60) @(posedge clk);
                chk(8'({tx_busy, txd}), 8'h01);
                cts <= 1'b0;
            end
        end
        results;
    end
endmodule
`default_nettype wire

// >>> tb/ubf_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubf_regs.vh"
// ********************************
// flow control and break checks
// ********************************
module ubf_core_props (
    // clocking
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       ce,
    // controls
    input wire logic [3:0] operating_mode,
    input wire logic       rx_enable,
    input wire logic       reset_status_bits,
    input wire logic       rx_dma_buffer_full,
    input wire logic       cts,
    // status and line
    input wire logic       rx_valid,
    input wire logic       break_received_flag,
    input wire logic       frame_error_flag,
    input wire logic       tx_busy,
    input wire logic       txd,
    input wire logic       rts
);
    wire logic hs = operating_mode == `UBF_MODE_HANDSHAKE;
    wire logic stop_rx = !rx_enable || rx_dma_buffer_full;
    wire logic keep = ce && !reset_status_bits;
    wire logic brk = break_received_flag;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    rts_high_a: assert property (ce && hs && stop_rx |=> rts)
        else $error("rts low while receive is blocked");
    rts_low_a: assert property (ce && hs && !stop_rx |=> !rts)
        else $error("rts high while receive is open");
    rts_off_a: assert property (ce && !hs |=> !rts)
        else $error("rts high outside handshake mode");
    brk_noframe_a: assert property ($rose(brk) |-> !$rose(frame_error_flag))
        else $error("break raised the framing error");
    brk_hold_a: assert property (keep && brk |=> brk)
        else $error("break flag lost without clear");
    fe_hold_a: assert property (keep && frame_error_flag |=> frame_error_flag)
        else $error("framing flag lost without clear");
    cts_hold_a: assert property (ce && hs && cts && !tx_busy |=> !tx_busy && txd)
        else $error("character started while cts high");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than a cycle");
    freeze_a: assert property (!ce |=> $stable(rts) && $stable(brk) && $stable(txd))
        else $error("state moved while frozen");
    brk_c: cover property ($rose(brk));
    hold_c: cover property (hs && cts && !tx_busy ##1 !cts);
    rx_c: cover property (rx_valid);
endmodule
bind ubf_core ubf_core_props u_props (
    .clk(clk), .resetn(resetn), .ce(ce), .operating_mode(operating_mode),
    .rx_enable(rx_enable), .reset_status_bits(reset_status_bits),
    .rx_dma_buffer_full(rx_dma_buffer_full), .cts(cts), .rx_valid(rx_valid),
    .break_received_flag(break_received_flag), .frame_error_flag(frame_error_flag),
    .tx_busy(tx_busy), .txd(txd), .rts(rts)
);
`default_nettype wire

// >>> tb/ubf_remote.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// remote serial device
// ********************************
module ubf_remote (
    // clocking
    input  wire logic clk,
    // its cts is fed by our rts
    input  wire logic rts,
    // line
    input  wire logic txd,
    output var logic  rxd
);
    // clocks per bit: 16 async, 1 in sync operation
    int bitc = 16;
    // idle line sits high, so a waiting remote never fakes a start bit
    initial rxd = 1'b1;
    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b);
        int k;
        while (rts !== 1'b0) @(posedge clk);
        hold(1'b0, bitc);
        for (k = 0; k < 8; k++) hold(b[k], bitc);
        hold(1'b1, bitc);
    endtask
    task automatic get(output logic [7:0] b);
        int k;
        while (txd !== 1'b0) @(posedge clk);
        repeat (bitc / 2) @(posedge clk);
        for (k = 0; k < 8; k++)
        begin
            repeat (bitc) @(posedge clk);
            b[k] = txd;
        end
        repeat (bitc) @(posedge clk);
    endtask
endmodule
`default_nettype wire
